// ---- core/display_hw_reset_sequencer.v ----
// Hardware reset sequencer of a display controller: glitch filter, blanking,
// settings reload from non-volatile memory and post-release command gating.
// Assumes reset_in_n is an asynchronous pin and nvm answers one word per strobe.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defines.vh"

module display_hw_reset_sequencer #(
    parameter [27:0] LOAD_CYC = `LOAD_MS * `MS_CYC,
    parameter [27:0] BLANK_CYC = `BLANK_MS * `MS_CYC,
    parameter [27:0] CMD_CYC = `CMD_WAIT_MS * `MS_CYC,
    parameter [27:0] WAKE_CYC = `WAKE_WAIT_MS * `MS_CYC
) (
    // Clock and core reset
    input wire clk,
    input wire rst_n,
    // Reset pin from host
    input wire reset_in_n,
    // Panel sleep state from command logic
    input wire sleeping,
    // Non-volatile memory read port
    output reg nvm_rd,
    output reg [7:0] nvm_addr,
    input wire [7:0] nvm_data,
    // Loaded settings
    output reg [7:0] id_byte0,
    output reg [7:0] id_byte1,
    output reg [7:0] id_byte2,
    output reg [7:0] common_electrode_level,
    // Status
    output reg in_reset,
    output reg blank,
    output reg regs_default,
    output reg cmd_ready,
    output reg wake_ready
);

localparam [2:0] S_RUN = 3'h0;
localparam [2:0] S_HELD = 3'h1;
localparam [2:0] S_LOAD = 3'h2;
localparam [2:0] S_WAIT = 3'h3;

reg pin_meta;
reg pin_sync;
wire [11:0] low_cnt;
wire [11:0] high_cnt;
wire low_clear;
reg [2:0] state;
reg was_awake;
reg [27:0] since_rel;
reg [7:0] word_idx;
reg load_done;
reg cap_pending;
reg [7:0] cap_addr;

always @(posedge clk) begin
    if (!rst_n) begin
        pin_meta <= 1'b1;
        pin_sync <= 1'b1;
    end else begin
        pin_meta <= reset_in_n;
        pin_sync <= pin_meta;
    end
end

// Low-time counter; while held, spikes high shorter than REJECT do not clear it
assign low_clear = pin_sync && (state != S_HELD || high_cnt >= `REJECT_CYC);

run_counter #(
    .WIDTH(12)
) u_low (
    .clk(clk),
    .rst_n(rst_n),
    .clear(low_clear),
    .count(!pin_sync),
    .value(low_cnt)
);

// High-time counter restarts on every low sample
run_counter #(
    .WIDTH(12)
) u_high (
    .clk(clk),
    .rst_n(rst_n),
    .clear(!pin_sync),
    .count(pin_sync),
    .value(high_cnt)
);

// Take reset only once low for the full time; middle band is never taken
wire take = (low_cnt >= `FULL_CYC);
// Release only after high long enough to be no spike
wire release_pin = pin_sync && (high_cnt >= `REJECT_CYC);

always @(posedge clk) begin
    if (!rst_n) begin
        state <= S_RUN;
        was_awake <= 1'b0;
        since_rel <= 28'h0;
        word_idx <= 8'h00;
        load_done <= 1'b0;
        nvm_rd <= 1'b0;
        nvm_addr <= 8'h00;
        in_reset <= 1'b0;
        blank <= 1'b0;
        regs_default <= 1'b0;
        cmd_ready <= 1'b1;
        wake_ready <= 1'b1;
    end else begin
        nvm_rd <= 1'b0;
        if (take && state != S_HELD) begin
            state <= S_HELD;
            was_awake <= !sleeping;
            in_reset <= 1'b1;
            blank <= 1'b1;
            regs_default <= 1'b1;
            cmd_ready <= 1'b0;
            wake_ready <= 1'b0;
        end else begin
            case (state)
                S_RUN: begin
                end
                S_HELD: begin
                    if (release_pin) begin
                        state <= S_LOAD;
                        since_rel <= 28'h0;
                        word_idx <= 8'h00;
                        load_done <= 1'b0;
                        in_reset <= 1'b0;
                    end
                end
                S_LOAD: begin
                    since_rel <= since_rel + 28'h1;
                    // Strobes run back to back; reload starts at once
                    if (word_idx != `LOAD_WORDS) begin
                        nvm_rd <= 1'b1;
                        nvm_addr <= word_idx;
                        word_idx <= word_idx + 8'h01;
                    end else if (!nvm_rd && !cap_pending) begin
                        // Done only once the last strobe has drained
                        load_done <= 1'b1;
                        regs_default <= 1'b0;
                        state <= S_WAIT;
                    end
                    // A memory that stops answering must not stall recovery
                    if (since_rel + 28'h1 >= LOAD_CYC) begin
                        regs_default <= 1'b0;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (since_rel != 28'hfffffff)
                        since_rel <= since_rel + 28'h1;
                    if (since_rel + 28'h1 >= CMD_CYC)
                        cmd_ready <= 1'b1;
                    // Asleep panel stays blank; awake one blanks up to 120 ms
                    if (was_awake && since_rel + 28'h1 >= BLANK_CYC)
                        blank <= 1'b0;
                    if (since_rel + 28'h1 >= WAKE_CYC) begin
                        wake_ready <= 1'b1;
                        state <= S_RUN;
                    end
                end
                default: state <= S_RUN;
            endcase
        end
    end
end

// Data stands the cycle after the strobe, so capture trails it by one flop
always @(posedge clk) begin
    if (!rst_n) begin
        cap_pending <= 1'b0;
        cap_addr <= 8'h00;
        id_byte0 <= 8'h00;
        id_byte1 <= 8'h00;
        id_byte2 <= 8'h00;
        common_electrode_level <= 8'h00;
    end else begin
        cap_pending <= nvm_rd;
        cap_addr <= nvm_addr;
        if (cap_pending) begin
            case (cap_addr)
                `ADDR_ID0: id_byte0 <= nvm_data;
                `ADDR_ID1: id_byte1 <= nvm_data;
                `ADDR_ID2: id_byte2 <= nvm_data;
                `ADDR_CEL: common_electrode_level <= nvm_data;
                default: begin
                end
            endcase
        end
    end
end

endmodule // display_hw_reset_sequencer

// Saturating run-length counter, one per pin level
module run_counter #(
    parameter WIDTH = 12
) (
    // Clock and core reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire clear,
    input wire count,
    // Count
    output reg [WIDTH-1:0] value
);

// Saturates so a long level never wraps into a short one
always @(posedge clk) begin
    if (!rst_n) begin
        value <= {WIDTH{1'b0}};
    end else if (clear) begin
        value <= {WIDTH{1'b0}};
    end else if (count && value != {WIDTH{1'b1}}) begin
        value <= value + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

endmodule // run_counter
`default_nettype wire

// ---- core/reset_seq_defines.vh ----
// Timing constants for the display hardware reset sequencer.
// Assumes a 250 MHz core clock; times are given in their own units.
`ifndef RESET_SEQ_DEFINES_VH
`define RESET_SEQ_DEFINES_VH

`define CLK_MHZ 250
`define REJECT_US 5
`define FULL_US 9
`define LOAD_MS 5
`define BLANK_MS 120
`define CMD_WAIT_MS 5
`define WAKE_WAIT_MS 120
// Reset taken once low for FULL_CYC cycles; below REJECT always rejected
`define REJECT_CYC (`REJECT_US * `CLK_MHZ)
`define FULL_CYC (`FULL_US * `CLK_MHZ)
`define MS_CYC (1000 * `CLK_MHZ)
`define LOAD_WORDS 8'h04
// Memory addresses of the stored settings
`define ADDR_ID0 8'h00
`define ADDR_ID1 8'h01
`define ADDR_ID2 8'h02
`define ADDR_CEL 8'h03

`endif

// ---- tb/reset_seq_assertions.sv ----
// Checker on the sequencer ports
// Bound below; counts in clk cycles
`timescale 1ns/1ps
`default_nettype none
module reset_seq_checker #(parameter [27:0] LOAD_CYC = 28'd1, WAKE_CYC = 28'd1) (
    // Watched ports
    input wire logic clk, rst_n, reset_in_n, nvm_rd, in_reset, blank, regs_default,
    input wire logic [7:0] nvm_addr
);
    logic [11:0] lo, hi;
    logic [27:0] rel;
    // Raw pin runs; the design lags by its two sync flops
    always @(posedge clk) begin
        lo <= (!rst_n || reset_in_n) ? 12'h0 : lo + {11'h0, lo != 12'hfff};
        hi <= (!rst_n || !reset_in_n) ? 12'h0 : hi + {11'h0, hi != 12'hfff};
        rel <= (!rst_n || in_reset) ? 28'h0 : rel + 28'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_short_ignored: assert property ($rose(in_reset) |-> lo > 12'd1250) else $error("short low");
    a_long_taken: assert property (lo == 12'd2300 |-> in_reset) else $error("long low missed");
    a_spike_held: assert property ($fell(in_reset) |-> hi >= 12'd1250) else $error("spike release");
    a_reload_order: assert property ($fell(in_reset) |-> ##[1:2] nvm_rd && nvm_addr == 8'h00
        ##1 nvm_addr == 8'h01 ##1 nvm_addr == 8'h02 ##1 nvm_rd && nvm_addr == 8'h03) else $error("reload");
    a_blank_reset: assert property (in_reset |-> blank && regs_default) else $error("not blank");
    a_load_bound: assert property ($fell(regs_default) |-> rel <= LOAD_CYC) else $error("slow load");
    a_awake_bound: assert property ($fell(blank) |-> rel <= WAKE_CYC) else $error("slow blank");
endmodule // reset_seq_checker
bind display_hw_reset_sequencer reset_seq_checker #(.LOAD_CYC(LOAD_CYC), .WAKE_CYC(WAKE_CYC)) u_chk (.*);
`default_nettype wire

// ---- tb/reset_host.sv ----
// Host model: drives the reset pin, answers memory reads
// Shares the sequencer clock
`timescale 1ns/1ps
`default_nettype none
module reset_host (
    // Memory side
    input wire logic clk,
    input wire logic nvm_rd,
    input wire logic [7:0] nvm_addr,
    output logic [7:0] nvm_data,
    // Pin
    output logic reset_in_n
);
    initial reset_in_n = 1'b1;
    initial nvm_data = 8'h00;
    // Toggles off-strobe so stale bytes never pass
    always @(posedge clk) nvm_data <= nvm_rd ? nvm_addr + 8'h5a : ~nvm_data;
    // Real resets are held >= 9.6 us (2400 cycles) by callers
    task hold(input logic lev, input int n);
        reset_in_n <= lev;
        repeat (n) @(posedge clk);
    endtask
endmodule // reset_host
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench: host model pulses the pin, tasks judge
// Short wait parameters
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, sleeping = 1'b0;
    wire logic reset_in_n, nvm_rd, in_reset, blank, regs_default, cmd_ready, wake_ready;
    wire logic [7:0] nvm_addr, nvm_data, id_byte0, id_byte1, id_byte2, common_electrode_level;
    int err_count = 0, n_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    display_hw_reset_sequencer #(.LOAD_CYC(28'd200), .BLANK_CYC(28'd2000), .CMD_CYC(28'd200),
        .WAKE_CYC(28'd2000)) DUT (.clk(clk), .rst_n(rst_n), .reset_in_n(reset_in_n), .sleeping(sleeping),
        .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .id_byte0(id_byte0), .id_byte1(id_byte1),
        .id_byte2(id_byte2), .common_electrode_level(common_electrode_level), .in_reset(in_reset),
        .blank(blank), .regs_default(regs_default), .cmd_ready(cmd_ready), .wake_ready(wake_ready));
    reset_host u_host (.clk(clk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .reset_in_n(reset_in_n));
    task chk(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task t_glitch;
        u_host.hold(1'b0, 2000);
        u_host.hold(1'b1, 4);
        #1 chk("in_reset", in_reset, 8'h0);
        u_host.hold(1'b1, 1400);
        $display("t_glitch done");
    endtask
    // Spike mid-pulse, then awake recovery
    task t_awake;
        u_host.hold(1'b0, 2400);
        u_host.hold(1'b1, 300);
        u_host.hold(1'b0, 300);
        #1 chk("in_reset", in_reset, 8'h1);
        u_host.hold(1'b1, 1270);
        #1 chk("in_reset", in_reset, 8'h0);
        chk("id0", id_byte0, 8'h5a);
        chk("id1", id_byte1, 8'h5b);
        chk("id2", id_byte2, 8'h5c);
        chk("cel", common_electrode_level, 8'h5d);
        chk("cmd", cmd_ready, 8'h0);
        u_host.hold(1'b1, 200);
        #1 chk("cmd", cmd_ready, 8'h1);
        chk("wake", wake_ready, 8'h0);
        u_host.hold(1'b1, 1800);
        #1 chk("blank", blank, 8'h0);
        chk("wake", wake_ready, 8'h1);
        $display("t_awake done");
    endtask
    task t_asleep;
        sleeping <= 1'b1;
        u_host.hold(1'b0, 2400);
        u_host.hold(1'b1, 3500);
        #1 chk("blank", blank, 8'h1);
        chk("defaults", regs_default, 8'h0);
        chk("cmd", cmd_ready, 8'h1);
        chk("wake", wake_ready, 8'h1);
        $display("t_asleep done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        u_host.hold(1'b1, 10);
        t_glitch;
        t_awake;
        t_asleep;
        final_report;
    end
    // Whole run needs about 15.6k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            final_report;
        end
    end
endmodule // tb_top
`default_nettype wire
